// >>> pkg/sag_pkg.sv
package sag_pkg;

	// ----------------------------------------
	// Opcode bytes and fields
	// ----------------------------------------
	localparam logic [7:0] PFX_EXT = 8'hED;
	localparam logic [7:0] PFX_IDX_X = 8'hDD;
	localparam logic [7:0] PFX_IDX_Y = 8'hFD;
	localparam logic [7:0] OPC_IDX_INC = 8'h23;
	localparam logic [7:0] OPC_IDX_DEC = 8'h2B;
	// Low nibble patterns, bits 3..0 (q bit and low three bits)
	localparam logic [3:0] LO_ADD = 4'h9;
	localparam logic [3:0] LO_ADC = 4'hA;
	localparam logic [3:0] LO_SUBB = 4'h2;
	localparam logic [3:0] LO_INC = 4'h3;
	localparam logic [3:0] LO_DEC = 4'hB;
	localparam logic [1:0] TOP_BASE = 2'h0;
	localparam logic [1:0] TOP_EXT = 2'h1;
	localparam int SEL_LSB = 4;

	// Pair-select codes
	localparam logic [1:0] SEL_ONE = 2'h0;
	localparam logic [1:0] SEL_TWO = 2'h1;
	localparam logic [1:0] SEL_SELF = 2'h2;
	localparam logic [1:0] SEL_STACK = 2'h3;

	// ----------------------------------------
	// Timing in clock states and machine cycles per form
	// ----------------------------------------
	localparam logic [4:0] T_ADD = 5'h0B;
	localparam logic [4:0] T_EXT = 5'h0F;
	localparam logic [4:0] T_INCDEC = 5'h06;
	localparam logic [4:0] T_IDX_INCDEC = 5'h0A;
	localparam logic [2:0] M_ADD = 3'h3;
	localparam logic [2:0] M_EXT = 3'h4;
	localparam logic [2:0] M_INCDEC = 3'h1;
	localparam logic [2:0] M_IDX_INCDEC = 3'h2;

	// Flag bit positions in the flag byte
	localparam int FL_C = 0;
	localparam int FL_N = 1;
	localparam int FL_PV = 2;
	localparam int FL_Z = 6;
	localparam int FL_S = 7;
	localparam logic [7:0] FLAGS_RST = 8'h00;
	localparam logic [15:0] PAIR_RST = 16'h0000;

	// Destination of a result
	typedef enum logic [5:0] {
		SAG_DST_ONE = 6'b000001,
		SAG_DST_TWO = 6'b000010,
		SAG_DST_PTR = 6'b000100,
		SAG_DST_STK = 6'b001000,
		SAG_DST_IDX_X = 6'b010000,
		SAG_DST_IDX_Y = 6'b100000
	} sag_dst_t;

	typedef enum logic [2:0] {
		SAG_IDLE = 3'b001,
		SAG_PFX = 3'b010,
		SAG_BUSY = 3'b100
	} sag_state_t;

	// Register-file view carried into the block
	typedef struct packed {
		logic [15:0] one;
		logic [15:0] two;
		logic [15:0] ptr;
		logic [15:0] stk;
		logic [15:0] idx_x;
		logic [15:0] idx_y;
	} sag_regs_t;

	// Result carried out of the block
	typedef struct packed {
		logic valid;
		sag_dst_t dst;
		logic [15:0] value;
		logic [7:0] flags;
		logic [2:0] mcycles;
		logic [4:0] tstates;
		logic [1:0] bytes;
	} sag_res_t;

endpackage

// >>> hdl/sag_core.sv
`timescale 1ns/1ps
module sag_core (
	input wire logic SYS_CLK,
	input wire logic SYS_RST,
	input wire logic OP_VALID,
	input wire logic [7:0] OP_BYTE,
	input wire sag_pkg::sag_regs_t REGS,
	input wire logic [7:0] FLAGS_IN,
	output sag_pkg::sag_res_t RESULT,
	output logic READY
);

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	sag_pkg::sag_state_t state_r;
	logic [7:0] pfx_r;
	logic [4:0] tcnt_r;
	logic [1:0] sel;
	logic [3:0] lo;
	logic [15:0] opa;
	logic [15:0] opb;
	logic [16:0] sum;
	logic [15:0] res;
	logic [7:0] fl;
	logic hit;
	logic is_pfx;
	sag_pkg::sag_dst_t dst;
	logic [4:0] ts;
	logic [2:0] mc;
	logic [1:0] nb;

	// All checks run on the one core clock, quiet during reset
	default clocking cb_chk @(posedge SYS_CLK);
	endclocking
	default disable iff (SYS_RST);

	assign sel = OP_BYTE[sag_pkg::SEL_LSB +: 2];
	assign lo = OP_BYTE[3:0];
	assign is_pfx = OP_BYTE == sag_pkg::PFX_EXT
		|| OP_BYTE == sag_pkg::PFX_IDX_X
		|| OP_BYTE == sag_pkg::PFX_IDX_Y;

	function automatic logic [15:0] pick(input sag_pkg::sag_regs_t r,
		input logic [1:0] s, input logic [15:0] self_v);
		case (s)
			sag_pkg::SEL_ONE: pick = r.one;
			sag_pkg::SEL_TWO: pick = r.two;
			sag_pkg::SEL_SELF: pick = self_v;
			default: pick = r.stk;
		endcase
	endfunction

	function automatic sag_pkg::sag_dst_t base_dst(input logic [1:0] s);
		case (s)
			sag_pkg::SEL_ONE: base_dst = sag_pkg::SAG_DST_ONE;
			sag_pkg::SEL_TWO: base_dst = sag_pkg::SAG_DST_TWO;
			sag_pkg::SEL_SELF: base_dst = sag_pkg::SAG_DST_PTR;
			default: base_dst = sag_pkg::SAG_DST_STK;
		endcase
	endfunction

	// Operation select, arithmetic and flags for the byte now offered
	always_comb begin
		hit = 1'b0;
		opa = REGS.ptr;
		opb = 16'h0000;
		sum = 17'h00000;
		res = 16'h0000;
		fl = FLAGS_IN;
		dst = sag_pkg::SAG_DST_PTR;
		ts = sag_pkg::T_ADD;
		mc = sag_pkg::M_ADD;
		nb = 2'h1;
		if (pfx_r == 8'h00) begin
			if (OP_BYTE[7:6] == sag_pkg::TOP_BASE) begin
				// Base page forms; add changes only N and C, keeps S, Z, P/V
				if (lo == sag_pkg::LO_ADD) begin
					hit = 1'b1;
					opb = pick(REGS, sel, REGS.ptr);
					sum = {1'b0, opa} + {1'b0, opb};
					res = sum[15:0];
					fl[sag_pkg::FL_N] = 1'b0;
					fl[sag_pkg::FL_C] = sum[16];
				end else if (lo == sag_pkg::LO_INC || lo == sag_pkg::LO_DEC) begin
					hit = 1'b1;
					opa = pick(REGS, sel, REGS.ptr);
					res = (lo == sag_pkg::LO_INC) ? opa + 16'h0001
						: opa - 16'h0001;
					dst = base_dst(sel);
					ts = sag_pkg::T_INCDEC;
					mc = sag_pkg::M_INCDEC;
				end
			end
		end else if (pfx_r == sag_pkg::PFX_EXT) begin
			if (OP_BYTE[7:6] == sag_pkg::TOP_EXT
				&& (lo == sag_pkg::LO_ADC || lo == sag_pkg::LO_SUBB)) begin
				hit = 1'b1;
				opb = pick(REGS, sel, REGS.ptr);
				if (lo == sag_pkg::LO_ADC) begin
					sum = {1'b0, opa} + {1'b0, opb}
						+ {16'h0000, FLAGS_IN[sag_pkg::FL_C]};
					fl[sag_pkg::FL_PV] = (opa[15] == opb[15])
						&& (sum[15] != opa[15]);
					fl[sag_pkg::FL_N] = 1'b0;
				end else begin
					sum = {1'b0, opa} - {1'b0, opb}
						- {16'h0000, FLAGS_IN[sag_pkg::FL_C]};
					fl[sag_pkg::FL_PV] = (opa[15] != opb[15])
						&& (sum[15] != opa[15]);
					fl[sag_pkg::FL_N] = 1'b1;
				end
				res = sum[15:0];
				fl[sag_pkg::FL_C] = sum[16];
				fl[sag_pkg::FL_S] = res[15];
				fl[sag_pkg::FL_Z] = res == 16'h0000;
				ts = sag_pkg::T_EXT;
				mc = sag_pkg::M_EXT;
				nb = 2'h2;
			end
		end else begin
			// Index forms: the prefix picks which index register is used
			opa = (pfx_r == sag_pkg::PFX_IDX_X) ? REGS.idx_x : REGS.idx_y;
			dst = (pfx_r == sag_pkg::PFX_IDX_X) ? sag_pkg::SAG_DST_IDX_X
				: sag_pkg::SAG_DST_IDX_Y;
			nb = 2'h2;
			if (OP_BYTE[7:6] == sag_pkg::TOP_BASE && lo == sag_pkg::LO_ADD) begin
				hit = 1'b1;
				opb = pick(REGS, sel, opa);
				sum = {1'b0, opa} + {1'b0, opb};
				res = sum[15:0];
				fl[sag_pkg::FL_N] = 1'b0;
				fl[sag_pkg::FL_C] = sum[16];
				ts = sag_pkg::T_EXT;
				mc = sag_pkg::M_EXT;
			end else if (OP_BYTE == sag_pkg::OPC_IDX_INC
				|| OP_BYTE == sag_pkg::OPC_IDX_DEC) begin
				hit = 1'b1;
				res = (OP_BYTE == sag_pkg::OPC_IDX_INC) ? opa + 16'h0001
					: opa - 16'h0001;
				ts = sag_pkg::T_IDX_INCDEC;
				mc = sag_pkg::M_IDX_INCDEC;
			end
		end
	end

	// ----------------------------------------
	// Sequencing
	// ----------------------------------------
	// Result is presented when the clock-state count has elapsed
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			state_r <= sag_pkg::SAG_IDLE;
			pfx_r <= 8'h00;
			tcnt_r <= 5'h00;
		end else begin
			case (state_r)
				sag_pkg::SAG_IDLE,
				sag_pkg::SAG_PFX: begin
					if (OP_VALID) begin
						if (state_r == sag_pkg::SAG_IDLE && is_pfx) begin
							pfx_r <= OP_BYTE;
							state_r <= sag_pkg::SAG_PFX;
						end else if (hit) begin
							tcnt_r <= ts - 5'h02;
							state_r <= sag_pkg::SAG_BUSY;
						end else begin
							// Foreign opcode: not ours, drop quietly
							pfx_r <= 8'h00;
							state_r <= sag_pkg::SAG_IDLE;
						end
					end
				end
				sag_pkg::SAG_BUSY: begin
					if (tcnt_r == 5'h00) begin
						pfx_r <= 8'h00;
						state_r <= sag_pkg::SAG_IDLE;
					end else begin
						tcnt_r <= tcnt_r - 5'h01;
					end
				end
				default: begin
					pfx_r <= 8'h00;
					state_r <= sag_pkg::SAG_IDLE;
				end
			endcase
		end
	end

	// Result latched at decode, valid strobed at the last clock state
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			RESULT <= '{valid: 1'b0, dst: sag_pkg::SAG_DST_PTR,
				value: sag_pkg::PAIR_RST, flags: sag_pkg::FLAGS_RST,
				mcycles: 3'h0, tstates: 5'h00, bytes: 2'h0};
		end else begin
			RESULT.valid <= state_r == sag_pkg::SAG_BUSY && tcnt_r == 5'h00;
			if (state_r != sag_pkg::SAG_BUSY && OP_VALID && hit
				&& !(state_r == sag_pkg::SAG_IDLE && is_pfx)) begin
				RESULT.dst <= dst;
				RESULT.value <= res;
				RESULT.flags <= fl;
				RESULT.mcycles <= mc;
				RESULT.tstates <= ts;
				RESULT.bytes <= nb;
			end
		end
	end

	// Ready low while an operation runs out its clock states
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			READY <= 1'b1;
		end else begin
			READY <= (state_r == sag_pkg::SAG_BUSY) ? tcnt_r == 5'h00
				: !(OP_VALID && hit
				&& !(state_r == sag_pkg::SAG_IDLE && is_pfx));
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_take_add;
		state_r == sag_pkg::SAG_IDLE && OP_VALID && hit
			&& lo == sag_pkg::LO_ADD && !is_pfx;
	endsequence

	// Valid lands on the eleventh edge after the opcode edge; the
	// opcode edge itself may still show the previous pulse
	sequence s_add_wait;
		!RESULT.valid [*8] ##1 !RESULT.valid [*2] ##1 RESULT.valid;
	endsequence

	AST_ADD_TIME: assert property (
		s_take_add |=> s_add_wait)
		else $error("base add result not at eleventh state");
	AST_ADD_NCLR: assert property (
		s_take_add |=> !RESULT.flags[sag_pkg::FL_N])
		else $error("base add left subtract flag set");
	AST_EXT_TIME: assert property (
		state_r == sag_pkg::SAG_PFX && pfx_r == sag_pkg::PFX_EXT
		&& OP_VALID && hit
		|-> ##15 RESULT.valid && RESULT.tstates == sag_pkg::T_EXT)
		else $error("extended op result not at fifteenth state");
	AST_SUBB_N: assert property (
		state_r == sag_pkg::SAG_PFX && pfx_r == sag_pkg::PFX_EXT
		&& OP_VALID && hit && lo == sag_pkg::LO_SUBB
		|=> RESULT.flags[sag_pkg::FL_N]
		&& RESULT.flags[sag_pkg::FL_Z] == (RESULT.value == 16'h0000))
		else $error("subtract flags wrong");
	AST_IDX_DST: assert property (
		state_r == sag_pkg::SAG_PFX && pfx_r == sag_pkg::PFX_IDX_X
		&& OP_VALID && hit |=> RESULT.dst == sag_pkg::SAG_DST_IDX_X)
		else $error("index_x op wrote wrong pair");
	AST_IDY_DST: assert property (
		state_r == sag_pkg::SAG_PFX && pfx_r == sag_pkg::PFX_IDX_Y
		&& OP_VALID && hit |=> RESULT.dst == sag_pkg::SAG_DST_IDX_Y)
		else $error("index_y op wrote wrong pair");
	AST_INC_FLAGS: assert property (
		state_r == sag_pkg::SAG_IDLE && OP_VALID && hit && !is_pfx
		&& lo != sag_pkg::LO_ADD |=> RESULT.flags == $past(FLAGS_IN)
		##5 RESULT.valid)
		else $error("pair inc/dec changed flags or timing");
	AST_INC_VAL: assert property (
		state_r == sag_pkg::SAG_IDLE && OP_VALID && hit && !is_pfx
		&& lo == sag_pkg::LO_DEC && sel == sag_pkg::SEL_ONE
		|=> RESULT.value == $past(REGS.one) - 16'h0001)
		else $error("pair decrement value wrong");
	AST_IDX_INC: assert property (
		state_r == sag_pkg::SAG_PFX && pfx_r == sag_pkg::PFX_IDX_X
		&& OP_VALID && OP_BYTE == sag_pkg::OPC_IDX_INC
		|=> RESULT.value == $past(REGS.idx_x) + 16'h0001
		##9 RESULT.valid)
		else $error("index increment wrong");

endmodule

// >>> tb/tb_sag_core.sv
`timescale 1ns/1ps
module tb_sag_core;
	logic SYS_CLK = 1'b0;
	logic SYS_RST = 1'b1;
	logic OP_VALID = 1'b0;
	logic [7:0] OP_BYTE = 8'h00;
	sag_pkg::sag_regs_t REGS = '0;
	logic [7:0] FLAGS_IN = 8'h00;
	sag_pkg::sag_res_t RESULT;
	logic READY;
	int num_errors = 0;
	int n_checks = 0;

	// ----------------------------------------
	// Clock, device, helpers
	// ----------------------------------------
	always #5 SYS_CLK = ~SYS_CLK;

	sag_core u_sag_core (
		.SYS_CLK(SYS_CLK),
		.SYS_RST(SYS_RST),
		.OP_VALID(OP_VALID),
		.OP_BYTE(OP_BYTE),
		.REGS(REGS),
		.FLAGS_IN(FLAGS_IN),
		.RESULT(RESULT),
		.READY(READY)
	);

	// Compare and count
	task automatic check(string w, logic [31:0] s, logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", w, e, s);
		end
	endtask

	task automatic summarize;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// One byte per call; valid stays up for a following byte, so the
	// caller drops it after the last byte of an instruction
	task automatic send(logic [7:0] b);
		int n;
		n = 0;
		while (READY !== 1'b1 && n < 40) begin
			OP_VALID = 1'b0;
			@(negedge SYS_CLK);
			n++;
		end
		check("ready", READY, 1'b1);
		OP_VALID = 1'b1;
		OP_BYTE = b;
		@(negedge SYS_CLK);
	endtask

	// Latency counted in edges after the opcode edge
	task automatic run(logic [7:0] p, logic [7:0] o, logic [5:0] d,
		logic [15:0] v, logic [7:0] f, logic [2:0] m, logic [4:0] t,
		logic [1:0] nb);
		int n;
		logic [15:0] got;
		if (nb == 2'h2) begin
			send(p);
		end
		send(o);
		OP_VALID = 1'b0;
		n = 0;
		while (RESULT.valid !== 1'b1 && n < 30) begin
			@(negedge SYS_CLK);
			n++;
		end
		check("latency", n, t - 1);
		check("value", RESULT.value, v);
		check("flags", RESULT.flags, f);
		got = {RESULT.dst, RESULT.mcycles, RESULT.tstates,
			RESULT.bytes};
		check("form", got, {d, m, t, nb});
		@(negedge SYS_CLK);
		check("pulse", RESULT.valid, 1'b0);
	endtask

	function automatic logic [15:0] pick(logic [1:0] s, logic [15:0] me);
		case (s)
			2'h0: return REGS.one;
			2'h1: return REGS.two;
			2'h2: return me;
			default: return REGS.stk;
		endcase
	endfunction

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// Old S, Z, P/V all set so a stray update shows
	task automatic t_add;
		logic [16:0] r;
		REGS = {16'h0001, 16'h7FFF, 16'hFFFF, 16'h8001, 16'h0, 16'h0};
		FLAGS_IN = 8'hFF;
		for (int s = 0; s < 4; s++) begin
			r = REGS.ptr + pick(s, REGS.ptr);
			run(8'h00, {2'h0, s[1:0], 4'h9}, 6'h04, r[15:0],
				{6'h3F, 1'b0, r[16]}, 3'h3, 5'h0B, 2'h1);
		end
		$display("add done");
	endtask

	// Carry in set; covers overflow, zero, carry and borrow
	task automatic t_carry_ops;
		logic [16:0] r;
		logic [15:0] a;
		logic [15:0] b;
		logic v;
		REGS = {16'h0000, 16'h8000, 16'h7FFF, 16'hFFFF, 16'h0, 16'h0};
		FLAGS_IN = 8'h11;
		a = REGS.ptr;
		for (int s = 0; s < 4; s++) begin
			b = pick(s, a);
			r = a + b + 1;
			v = a[15] == b[15] && r[15] != a[15];
			run(8'hED, {2'h1, s[1:0], 4'hA}, 6'h04, r[15:0],
				{r[15], r[15:0] == 0, 3'h2, v, 1'b0, r[16]},
				3'h4, 5'h0F, 2'h2);
			r = {1'b0, a} - {1'b0, b} - 1;
			v = a[15] != b[15] && r[15] != a[15];
			run(8'hED, {2'h1, s[1:0], 4'h2}, 6'h04, r[15:0],
				{r[15], r[15:0] == 0, 3'h2, v, 1'b1, r[16]},
				3'h4, 5'h0F, 2'h2);
		end
		$display("carry ops done");
	endtask

	// Code 10 must take the index itself, never the pointer pair
	task automatic t_idx_add;
		logic [16:0] r;
		REGS = {16'h8001, 16'h0002, 16'h1111, 16'h0100, 16'h8000, 16'hFFFF};
		FLAGS_IN = 8'hC6;
		for (int s = 0; s < 4; s++) begin
			r = REGS.idx_x + pick(s, REGS.idx_x);
			run(8'hDD, {2'h0, s[1:0], 4'h9}, 6'h10, r[15:0],
				{7'h62, r[16]}, 3'h4, 5'h0F, 2'h2);
			r = REGS.idx_y + pick(s, REGS.idx_y);
			run(8'hFD, {2'h0, s[1:0], 4'h9}, 6'h20, r[15:0],
				{7'h62, r[16]}, 3'h4, 5'h0F, 2'h2);
		end
		$display("index add done");
	endtask

	// Wrap at both ends; flags must pass untouched
	task automatic t_incdec;
		logic [15:0] b;
		REGS = {16'hFFFF, 16'h0000, 16'h1234, 16'h8000, 16'h0, 16'h0};
		FLAGS_IN = 8'hA5;
		for (int s = 0; s < 4; s++) begin
			b = pick(s, REGS.ptr);
			run(8'h00, {2'h0, s[1:0], 4'h3}, 6'(1 << s), b + 1, 8'hA5,
				3'h1, 5'h06, 2'h1);
			run(8'h00, {2'h0, s[1:0], 4'hB}, 6'(1 << s), b - 1, 8'hA5,
				3'h1, 5'h06, 2'h1);
		end
		$display("inc dec done");
	endtask

	// A prefix after a prefix, and an unknown extended opcode
	task automatic t_refuse;
		int hits;
		hits = 0;
		send(8'hDD);
		send(8'hED);
		send(8'hED);
		send(8'h00);
		OP_VALID = 1'b0;
		repeat (20) begin
			@(negedge SYS_CLK);
			hits += RESULT.valid === 1'b1;
		end
		check("dropped", hits, 0);
		$display("refuse done");
	endtask

	task automatic t_idx_incdec;
		REGS = {16'h0, 16'h0, 16'h0, 16'h0, 16'hFFFF, 16'h0000};
		FLAGS_IN = 8'h5A;
		run(8'hDD, 8'h23, 6'h10, 16'h0000, 8'h5A, 3'h2, 5'h0A,
			2'h2);
		run(8'hFD, 8'h23, 6'h20, 16'h0001, 8'h5A, 3'h2, 5'h0A,
			2'h2);
		run(8'hDD, 8'h2B, 6'h10, 16'hFFFE, 8'h5A, 3'h2, 5'h0A,
			2'h2);
		run(8'hFD, 8'h2B, 6'h20, 16'hFFFF, 8'h5A, 3'h2, 5'h0A,
			2'h2);
		$display("index inc dec done");
	endtask

	// ----------------------------------------
	// Sequence and watchdog
	// ----------------------------------------
	// Run needs well under 1500 cycles; 5000 leaves margin
	initial begin
		#50000;
		num_errors++;
		summarize();
	end

	initial begin
		repeat (16) @(negedge SYS_CLK);
		SYS_RST = 1'b0;
		check("ready", READY, 1'b1);
		t_add();
		t_carry_ops();
		t_idx_add();
		t_incdec();
		t_refuse();
		t_idx_incdec();
		summarize();
	end
endmodule
